// ### design/pci_status_bar_pkg.sv
// shared constants for the status and window base register bank
package pci_status_bar_pkg;

  // configuration dword indices (byte address = index * 4)
  localparam logic [5:0] CFG_CMD_STATUS_IDX = 6'h01;
  localparam logic [5:0] CFG_WINDOW_BASE_IDX = 6'h04;

  // status register field positions
  localparam int ST_CAP_LIST = 4;
  localparam int ST_66MHZ = 5;
  localparam int ST_FAST_B2B = 7;
  localparam int ST_MASTER_PERR = 8;
  localparam int ST_DEVSEL_LO = 9;
  localparam int ST_DEVSEL_HI = 10;
  localparam int ST_SIG_TABORT = 11;
  localparam int ST_RCV_TABORT = 12;
  localparam int ST_RCV_MABORT = 13;
  localparam int ST_SIG_SERR = 14;
  localparam int ST_DET_PERR = 15;

  // sticky flags, in order from status bit 8 upward, skipping the timing field
  localparam int NUM_FLAGS = 6;
  localparam int FL_MASTER_PERR = 0;
  localparam int FL_SIG_TABORT = 1;
  localparam int FL_RCV_TABORT = 2;
  localparam int FL_RCV_MABORT = 3;
  localparam int FL_SIG_SERR = 4;
  localparam int FL_DET_PERR = 5;

  // fixed field values
  localparam logic CAP_LIST_VALUE = 1'h1;
  localparam logic MHZ66_VALUE = 1'h0;
  localparam logic FAST_B2B_VALUE = 1'h0;
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;

  // window base register fields
  localparam int WB_SPACE = 0;
  localparam int WB_TYPE_LO = 1;
  localparam int WB_TYPE_HI = 2;
  localparam int WB_PREFETCH = 3;
  localparam int WB_LOW_LO = 4;
  localparam int WB_LOW_HI = 11;
  localparam int WB_BASE_LO = 12;
  localparam int WB_BASE_HI = 31;
  localparam int WB_BASE_BITS = 20;
  localparam logic WB_SPACE_VALUE = 1'h0;
  localparam logic [1:0] WB_TYPE_VALUE = 2'h0;
  localparam logic WB_PREFETCH_VALUE = 1'h0;
  localparam logic [7:0] WB_LOW_VALUE = 8'h00;
  localparam logic [19:0] WB_BASE_RESET = 20'h00000;

  // byte lanes
  localparam int BE_STATUS_LO = 2;
  localparam int BE_STATUS_HI = 3;
  localparam int BE_WB_B1 = 1;
  localparam int BE_WB_B2 = 2;
  localparam int BE_WB_B3 = 3;

  localparam logic [31:0] READ_ZERO = 32'h00000000;

endpackage

// ### design/sticky_flags.sv
// bank of event flags that hardware sets and a write of one clears
`timescale 1ns/1ps
`default_nettype none

module sticky_flags
  import pci_status_bar_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // events and clears
  input wire logic [NUM_FLAGS-1:0] setPulse,
  input wire logic [NUM_FLAGS-1:0] clearPulse,
  // flag state
  output logic [NUM_FLAGS-1:0] flags
);

  typedef struct packed {
    logic [NUM_FLAGS-1:0] flags;
  } flag_state_t;

  flag_state_t state;
  flag_state_t next_state;

  // set wins over a clear in the same cycle; a zero written leaves the flag
  always_comb begin
    next_state = state;
    for (int i = 0; i < NUM_FLAGS; i++) begin
      if (setPulse[i]) begin
        next_state.flags[i] = 1'b1;
      end else if (clearPulse[i]) begin
        next_state.flags[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;

endmodule

`default_nettype wire

// ### design/pci_status_and_base_address_regs.sv
// configuration status register and operational window base register
`timescale 1ns/1ps
`default_nettype none

module pci_status_and_base_address_regs
  import pci_status_bar_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // configuration access
  input wire logic cfgRead,
  input wire logic cfgWrite,
  input wire logic [5:0] cfgDword,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWriteData,
  output logic [31:0] cfgReadData,
  output logic cfgDone,
  // command register bits held elsewhere
  input wire logic memSpaceEnable,
  input wire logic parityErrorResponse,
  // bus events
  input wire logic perrSeen,
  input wire logic actingMaster,
  input wire logic targetAbortSignaled,
  input wire logic targetAbortReceived,
  input wire logic masterAbortIssued,
  input wire logic serrDriven,
  input wire logic parityErrorDetected,
  input wire logic perrRequest,
  // perr gating
  output logic perrDrive,
  // memory decode
  input wire logic memCycleStart,
  input wire logic [31:0] memAddress,
  output logic memClaim,
  output logic [1:0] devselTiming
);

  typedef struct packed {
    logic [WB_BASE_BITS-1:0] windowBase;
    logic [31:0] readData;
    logic done;
  } regs_state_t;

  regs_state_t state;
  regs_state_t next_state;

  logic [NUM_FLAGS-1:0] flagSet;
  logic [NUM_FLAGS-1:0] flagClear;
  logic [NUM_FLAGS-1:0] flags;
  logic [15:0] statusValue;
  logic [31:0] windowValue;
  logic statusWrite;
  logic windowWrite;

  // status half sits above the command half in its dword
  localparam int STATUS_SHIFT = 16;
  localparam int LANE_BITS = 8;

  function automatic logic dwordHit(input logic [5:0] dword, input logic [5:0] idx);
    return dword == idx;
  endfunction

  // status bit that each sticky flag occupies
  function automatic int flagPos(input int fl);
    case (fl)
      FL_MASTER_PERR: return ST_MASTER_PERR;
      FL_SIG_TABORT: return ST_SIG_TABORT;
      FL_RCV_TABORT: return ST_RCV_TABORT;
      FL_RCV_MABORT: return ST_RCV_MABORT;
      FL_SIG_SERR: return ST_SIG_SERR;
      default: return ST_DET_PERR;
    endcase
  endfunction

  // byte lane that carries a given status bit
  function automatic int laneOf(input int pos);
    if (pos < LANE_BITS) begin
      return BE_STATUS_LO;
    end
    return BE_STATUS_HI;
  endfunction

  // read image of one configuration dword; unmapped dwords read zero
  function automatic logic [31:0] readImage(input logic [5:0] dword,
                                            input logic [15:0] status,
                                            input logic [31:0] window);
    logic [31:0] img;
    img = READ_ZERO;
    if (dwordHit(dword, CFG_CMD_STATUS_IDX)) begin
      img = {status, 16'h0000};
    end else if (dwordHit(dword, CFG_WINDOW_BASE_IDX)) begin
      img = window;
    end
    return img;
  endfunction

  // hardware event sources for the sticky flags
  always_comb begin
    flagSet = '0;
    flagSet[FL_MASTER_PERR] = perrSeen & actingMaster & parityErrorResponse;
    flagSet[FL_SIG_TABORT] = targetAbortSignaled;
    flagSet[FL_RCV_TABORT] = targetAbortReceived;
    flagSet[FL_RCV_MABORT] = masterAbortIssued;
    flagSet[FL_SIG_SERR] = serrDriven;
    flagSet[FL_DET_PERR] = parityErrorDetected;
  end

  assign statusWrite = cfgWrite & dwordHit(cfgDword, CFG_CMD_STATUS_IDX);
  assign windowWrite = cfgWrite & dwordHit(cfgDword, CFG_WINDOW_BASE_IDX);

  // write-one-to-clear per byte lane; zeros leave flags alone
  // each flag clears through the lane that holds its status bit
  for (genvar g = 0; g < NUM_FLAGS; g++) begin : g_clear
    assign flagClear[g] = statusWrite &
                          cfgByteEn[laneOf(flagPos(g))] &
                          cfgWriteData[STATUS_SHIFT + flagPos(g)];
  end

  sticky_flags flagBank (
    .core_clk(core_clk),
    .resetn(resetn),
    .setPulse(flagSet),
    .clearPulse(flagClear),
    .flags(flags)
  );

  // status image; fixed fields are constants so writes cannot touch them
  always_comb begin
    statusValue = '0;
    statusValue[ST_CAP_LIST] = CAP_LIST_VALUE;
    statusValue[ST_66MHZ] = MHZ66_VALUE;
    statusValue[ST_FAST_B2B] = FAST_B2B_VALUE;
    statusValue[ST_MASTER_PERR] = flags[FL_MASTER_PERR];
    statusValue[ST_DEVSEL_HI:ST_DEVSEL_LO] = DEVSEL_MEDIUM;
    statusValue[ST_SIG_TABORT] = flags[FL_SIG_TABORT];
    statusValue[ST_RCV_TABORT] = flags[FL_RCV_TABORT];
    statusValue[ST_RCV_MABORT] = flags[FL_RCV_MABORT];
    statusValue[ST_SIG_SERR] = flags[FL_SIG_SERR];
    statusValue[ST_DET_PERR] = flags[FL_DET_PERR];
  end

  // window base image
  always_comb begin
    windowValue = '0;
    windowValue[WB_SPACE] = WB_SPACE_VALUE;
    windowValue[WB_TYPE_HI:WB_TYPE_LO] = WB_TYPE_VALUE;
    windowValue[WB_PREFETCH] = WB_PREFETCH_VALUE;
    windowValue[WB_LOW_HI:WB_LOW_LO] = WB_LOW_VALUE;
    windowValue[WB_BASE_HI:WB_BASE_LO] = state.windowBase;
  end

  always_comb begin
    next_state = state;
    next_state.done = cfgRead | cfgWrite;
    // only the upper 20 base bits take write data, lane by lane
    if (windowWrite) begin
      if (cfgByteEn[BE_WB_B1]) begin
        next_state.windowBase[3:0] = cfgWriteData[15:12];
      end
      if (cfgByteEn[BE_WB_B2]) begin
        next_state.windowBase[11:4] = cfgWriteData[23:16];
      end
      if (cfgByteEn[BE_WB_B3]) begin
        next_state.windowBase[19:12] = cfgWriteData[31:24];
      end
    end
    // command half of the status dword is held elsewhere and reads zero here
    if (cfgRead) begin
      next_state.readData = readImage(cfgDword, statusValue, windowValue);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state.windowBase <= WB_BASE_RESET;
      state.readData <= READ_ZERO;
      state.done <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign cfgReadData = state.readData;
  assign cfgDone = state.done;
  assign perrDrive = perrRequest & parityErrorResponse;
  assign devselTiming = DEVSEL_MEDIUM;
  assign memClaim = memCycleStart & memSpaceEnable &
                    (memAddress[WB_BASE_HI:WB_BASE_LO] == state.windowBase);

endmodule

`default_nettype wire

// ### verif/pci_status_regs_monitor.sv
// checker for the status and window base register bank
`timescale 1ns/1ps
`default_nettype none
module pci_status_regs_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // configuration access
  input wire logic cfgRead,
  input wire logic cfgWrite,
  input wire logic [5:0] cfgDword,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWriteData,
  input wire logic [31:0] cfgReadData,
  // bus side
  input wire logic parityErrorResponse,
  input wire logic perrRequest,
  input wire logic perrDrive,
  input wire logic parityErrorDetected,
  input wire logic targetAbortSignaled,
  input wire logic memCycleStart,
  input wire logic memSpaceEnable,
  input wire logic memClaim,
  input wire logic [1:0] devselTiming
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_st; cfgRead && cfgDword == 6'h01; endsequence
  sequence s_wbw; cfgWrite && !cfgRead && cfgDword == 6'h04 && cfgByteEn == 4'hf; endsequence
  sequence s_wbr; cfgRead && !cfgWrite && cfgDword == 6'h04; endsequence
  property p_b2b; s_st |=> !cfgReadData[23]; endproperty
  property p_dvs; s_st |=> cfgReadData[26:25] == 2'h1 && devselTiming == 2'h1; endproperty
  property p_wlow; s_wbr |=> cfgReadData[11:0] == 12'h000; endproperty
  property p_wbase; s_wbw ##2 s_wbr |=> cfgReadData[31:12] == $past(cfgWriteData[31:12], 3); endproperty
  property p_perr; perrDrive == (perrRequest && parityErrorResponse); endproperty
  property p_claim; memClaim |-> memCycleStart && memSpaceEnable; endproperty
  property p_det; parityErrorDetected ##2 s_st |=> cfgReadData[31]; endproperty
  property p_tab; targetAbortSignaled ##2 s_st |=> cfgReadData[27]; endproperty
  property p_hold; !cfgRead |=> $stable(cfgReadData); endproperty
  a_b2b: assert property (p_b2b) else $error("fast back-to-back bit set");
  a_dvs: assert property (p_dvs) else $error("select timing not medium");
  a_wlow: assert property (p_wlow) else $error("window low bits not zero");
  a_wbase: assert property (p_wbase) else $error("window base not written");
  a_perr: assert property (p_perr) else $error("parity drive gating wrong");
  a_claim: assert property (p_claim) else $error("claim without enable");
  a_det: assert property (p_det) else $error("detected parity flag missing");
  a_tab: assert property (p_tab) else $error("target abort flag missing");
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind pci_status_and_base_address_regs pci_status_regs_monitor pci_status_regs_monitor_inst (
  .core_clk(core_clk), .resetn(resetn), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
  .cfgDword(cfgDword), .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData),
  .cfgReadData(cfgReadData), .parityErrorResponse(parityErrorResponse),
  .perrRequest(perrRequest), .perrDrive(perrDrive), .parityErrorDetected(parityErrorDetected),
  .targetAbortSignaled(targetAbortSignaled), .memCycleStart(memCycleStart),
  .memSpaceEnable(memSpaceEnable), .memClaim(memClaim), .devselTiming(devselTiming));
`default_nettype wire

// ### verif/pci_bus_agent.sv
// behavioural bus agent pulsing the bus event lines
`timescale 1ns/1ps
`default_nettype none
module pci_bus_agent (
  // clock
  input wire logic core_clk,
  // events: det parity, serr, mabort, rcv tabort, sig tabort, master, perr
  output logic [6:0] busEvent
);
  initial busEvent = 7'h00;
  // one cycle pulse between falling edges
  task automatic fire(input logic [6:0] v);
    @(negedge core_clk);
    busEvent = v;
    @(negedge core_clk);
    busEvent = 7'h00;
  endtask
endmodule
`default_nettype wire

// ### verif/pci_status_and_base_address_regs_test.sv
// self-checking bench for the status and window base register bank
`timescale 1ns/1ps
`default_nettype none
module pci_status_and_base_address_regs_test;
  logic core_clk = 1'b0, resetn = 1'b0, cfgRead = 1'b0, cfgWrite = 1'b0;
  logic [5:0] cfgDword = 6'h00;
  logic [3:0] cfgByteEn = 4'h0;
  logic [31:0] cfgWriteData = 32'h0, memAddress = 32'h0, s = 32'h96b6, w = 32'h0;
  logic [31:0] cfgReadData, rdat;
  logic memSpaceEnable = 1'b0, parityErrorResponse = 1'b0, perrRequest = 1'b0;
  logic memCycleStart = 1'b0, cfgDone, perrDrive, memClaim;
  logic [1:0] devselTiming;
  logic [6:0] busEvent;
  logic [15:0] m;
  logic [11:0] tbl [8] = '{12'h838, 12'h030, 12'h810, 12'h84b, 12'h08c, 12'h10d, 12'h20e, 12'h40f};
  int n_fail = 0, n_compared = 0;
  pci_bus_agent pci_bus_agent_inst (.core_clk(core_clk), .busEvent(busEvent));
  pci_status_and_base_address_regs pci_status_and_base_address_regs_inst (
    .core_clk(core_clk), .resetn(resetn), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
    .cfgDword(cfgDword), .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData),
    .cfgReadData(cfgReadData), .cfgDone(cfgDone), .memSpaceEnable(memSpaceEnable),
    .parityErrorResponse(parityErrorResponse), .perrSeen(busEvent[0]),
    .actingMaster(busEvent[1]), .targetAbortSignaled(busEvent[2]),
    .targetAbortReceived(busEvent[3]), .masterAbortIssued(busEvent[4]),
    .serrDriven(busEvent[5]), .parityErrorDetected(busEvent[6]), .perrRequest(perrRequest),
    .perrDrive(perrDrive), .memCycleStart(memCycleStart), .memAddress(memAddress),
    .memClaim(memClaim), .devselTiming(devselTiming));
  initial forever #10 core_clk = ~core_clk;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // expected window after a write through lanes 1 to 3
  function automatic logic [31:0] mg(input logic [31:0] o, d, input logic [3:0] b);
    mg = o;
    if (b[1]) mg[15:12] = d[15:12];
    if (b[2]) mg[23:16] = d[23:16];
    if (b[3]) mg[31:24] = d[31:24];
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cfg(input logic rd, wr, input logic [5:0] dw, input logic [3:0] be,
                     input logic [31:0] d);
    @(negedge core_clk);
    {cfgRead, cfgWrite, cfgDword, cfgByteEn, cfgWriteData} = {rd, wr, dw, be, d};
    @(negedge core_clk);
    {cfgRead, cfgWrite} = 2'b00;
    cmp("done", 32'h1, {31'h0, cfgDone});
    rdat = cfgReadData;
  endtask
  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    cfg(1'b1, 1'b0, 6'h01, 4'h0, 32'h0);
    cmp("status", 32'h02100000, rdat);
    cfg(1'b1, 1'b0, 6'h04, 4'h0, 32'h0);
    cmp("window", 32'h0, rdat);
    cfg(1'b0, 1'b1, 6'h01, 4'hf, 32'hffffffff);
    cfg(1'b1, 1'b0, 6'h02, 4'h0, 32'h0);
    cmp("unmapped", 32'h0, rdat);
    cfg(1'b1, 1'b0, 6'h01, 4'h0, 32'h0);
    cmp("status", 32'h02100000, rdat);
    $display("test fixed fields done");
    for (int i = 0; i < 8; i++) begin
      s = nxt(s);
      w = mg(w, s, i ? s[3:0] : 4'hf);
      cfg(1'b0, 1'b1, 6'h04, i ? s[3:0] : 4'hf, s);
      cfg(1'b1, 1'b0, 6'h04, 4'h0, 32'h0);
      cmp("window", w, rdat);
      {memCycleStart, memSpaceEnable, perrRequest, parityErrorResponse} = {1'b1, s[4], s[7:6]};
      memAddress = {w[31:12] ^ {19'h0, s[5]}, s[11:0]};
      #1 cmp("claim", {31'h0, s[4] & ~s[5]}, {31'h0, memClaim});
      cmp("perr", {31'h0, s[7] & s[6]}, {31'h0, perrDrive});
      cmp("devsel", 32'h1, {30'h0, devselTiming});
    end
    $display("test window done");
    for (int i = 0; i < 8; i++) begin
      m = tbl[i][3:0] ? 16'h1 << tbl[i][3:0] : 16'h0;
      parityErrorResponse = tbl[i][11];
      pci_bus_agent_inst.fire(tbl[i][10:4]);
      cfg(1'b1, 1'b0, 6'h01, 4'h0, 32'h0);
      cmp("flags", {16'h0210 | m, 16'h0}, rdat);
      cfg(1'b0, 1'b1, 6'h01, 4'hc, 32'h0);
      cfg(1'b1, 1'b0, 6'h01, 4'h0, 32'h0);
      cmp("flags", {16'h0210 | m, 16'h0}, rdat);
      cfg(1'b0, 1'b1, 6'h01, 4'hc, {m, 16'h0});
      cfg(1'b1, 1'b0, 6'h01, 4'h0, 32'h0);
      cmp("flags", 32'h02100000, rdat);
    end
    $display("test flags done");
    resetn = 1'b0;
    @(negedge core_clk);
    resetn = 1'b1;
    cfg(1'b1, 1'b0, 6'h04, 4'h0, 32'h0);
    cmp("window", 32'h0, rdat);
    $display("test second reset done");
    complete_run();
  end
endmodule
`default_nettype wire
